// >>> rtl/ppp_pkg.sv
// Package for the printer parallel port: register map, field positions,
// reset values, timing counts and the pin carrier structs.
// Assumes a 25 MHz system clock and a 32-bit APB register bus.
package ppp_pkg;

    // =========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_ISTS = 8'h0C;
    localparam logic [7:0] OFS_IMSK = 8'h10;

    // =========================================================
    // Control fields
    localparam int CTRL_INIT  = 0;
    localparam int CTRL_CTX   = 1;
    localparam int CTRL_RT_LO = 2;
    localparam logic [3:0] CTRL_RST = 4'h8;

    // Interrupt route codes; code 3 falls back to the normal request.
    localparam logic [1:0] RT_NMI  = 2'h0;
    localparam logic [1:0] RT_FAST = 2'h1;
    localparam logic [1:0] RT_IRQ  = 2'h2;

    // =========================================================
    // Status and interrupt bits
    localparam int ST_FAULT = 0;
    localparam int ST_BUSY  = 1;
    localparam int ST_PAPER = 2;
    localparam int ST_SEL   = 3;
    localparam int ST_CRX   = 4;
    localparam int ST_PEND  = 5;
    localparam int ST_STB   = 6;
    localparam int EV_ACK   = 0;
    localparam int EV_SENT  = 1;
    localparam int EV_FAULT = 2;
    localparam int EV_PAPER = 3;
    localparam int EV_W     = 4;

    // =========================================================
    // Timing
    localparam int CLK_NS  = 40;
    localparam int STB_NS  = 1000;
    localparam int STB_CYC = (STB_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [4:0] STB_LAST = 5'(STB_CYC - 1);

    // =========================================================
    // Pin carriers
    typedef struct packed {
        logic ack_n;
        logic fault_n;
        logic busy;
        logic paper_out;
        logic selected;
        logic cassette_rx;
    } ppp_pin_in_s;

    typedef struct packed {
        logic [7:0] printer_data;
        logic       data_strobe;
        logic       printer_init_n;
        logic       cassette_tx;
    } ppp_pin_out_s;

    typedef struct packed {
        logic nmi_n;
        logic fast_n;
        logic irq_n;
    } ppp_irq_s;

endpackage

// >>> rtl/ppp_top.sv
// Printer parallel port: APB slave, character strobe engine, cassette bits
// and a routed interrupt.
// Assumes printer pins are synchronous to clk and an APB master on clk.
`timescale 1ns/1ps
`default_nettype none

module ppp_top (
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic               ce,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire ppp_pkg::ppp_pin_in_s  pin_in,
    output ppp_pkg::ppp_pin_out_s      pin_out,
    output ppp_pkg::ppp_irq_s          irq_out,
    output logic                    int_lvl
);
    import ppp_pkg::*;

    // =========================================================
    // Helpers

    // One-hot active-high select of the processor input for a route code.
    function automatic logic [2:0] route_dec(input logic [1:0] rt);
        case (rt)
            RT_NMI:  route_dec = 3'h4;
            RT_FAST: route_dec = 3'h2;
            default: route_dec = 3'h1;
        endcase
    endfunction

    // =========================================================
    // State
    logic [7:0]      porta_r;
    logic [3:0]      ctrl_r;
    logic [EV_W-1:0] ists_r;
    logic [EV_W-1:0] imsk_r;
    logic            pend_r;
    logic            stb_r;
    logic [4:0]      stb_cnt_r;
    ppp_pin_in_s     pin_prev_r;
    logic [31:0]     prdata_r;
    logic            pready_r;
    logic            pslverr_r;
    logic            int_r;
    logic [2:0]      route_r;   // Active-low requests, nmi, fast, irq.
    logic            init_n_r;

    logic            acc;
    logic            wr_data;
    logic            data_lock;
    logic            start;
    logic            stb_end;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;
    logic [EV_W-1:0] ists_nxt;
    logic            int_nxt;
    logic            bad_addr;
    logic [31:0]     rd_mux;

    // =========================================================
    // Bus decode. Access phase is answered one cycle after it starts, so
    // every answer comes from a flip-flop.
    assign acc       = ce && psel && penable && !pready_r;
    assign data_lock = pend_r || stb_r;
    assign wr_data   = acc && pwrite && (paddr == OFS_DATA) && !data_lock;
    assign bad_addr  = (paddr != OFS_DATA) && (paddr != OFS_CTRL) &&
                       (paddr != OFS_STAT) && (paddr != OFS_ISTS) &&
                       (paddr != OFS_IMSK);

    // Read multiplexer; reserved bits read as zero.
    always_comb begin
        if (paddr == OFS_DATA) begin
            rd_mux = {24'h000000, porta_r};
        end else if (paddr == OFS_CTRL) begin
            rd_mux = {28'h0000000, ctrl_r};
        end else if (paddr == OFS_STAT) begin
            rd_mux = {25'h0000000, stb_r, pend_r, pin_in.cassette_rx,
                      pin_in.selected, pin_in.paper_out, pin_in.busy,
                      !pin_in.fault_n};
        end else if (paddr == OFS_ISTS) begin
            rd_mux = {28'h0000000, ists_r};
        end else if (paddr == OFS_IMSK) begin
            rd_mux = {28'h0000000, imsk_r};
        end else begin
            rd_mux = 32'h00000000;
        end
    end

    // Answer registers. A data write during a pending character is refused
    // with an error so the printed byte cannot change under the strobe.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end else if (ce) begin
            pready_r  <= acc;
            pslverr_r <= acc && (bad_addr || (pwrite &&
                         (paddr == OFS_DATA) && data_lock));
            prdata_r  <= (acc && !pwrite) ? rd_mux : 32'h00000000;
        end
    end

    // Port A data register feeds the data pins bit for bit.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            porta_r <= 8'h00;
        end else if (ce && wr_data) begin
            porta_r <= pwdata[7:0];
        end
    end

    // Control: init line, cassette transmit and interrupt route.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r   <= CTRL_RST;
            imsk_r   <= '0;
            init_n_r <= !CTRL_RST[CTRL_INIT];
        end else if (ce && acc && pwrite) begin
            if (paddr == OFS_CTRL) begin
                ctrl_r   <= pwdata[3:0];
                init_n_r <= !pwdata[CTRL_INIT];
            end else if (paddr == OFS_IMSK) begin
                imsk_r <= pwdata[EV_W-1:0];
            end
        end
    end

    // =========================================================
    // Strobe engine. A written character waits until the printer is idle
    // and online, then one strobe of the fixed width is sent.
    assign start   = pend_r && !stb_r && !pin_in.busy && pin_in.selected;
    assign stb_end = stb_r && (stb_cnt_r == STB_LAST);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pend_r    <= 1'b0;
            stb_r     <= 1'b0;
            stb_cnt_r <= 5'h00;
        end else if (ce) begin
            if (wr_data) begin
                pend_r <= 1'b1;
            end else if (start) begin
                pend_r <= 1'b0;
            end
            if (start) begin
                stb_r     <= 1'b1;
                stb_cnt_r <= 5'h00;
            end else if (stb_end) begin
                stb_r     <= 1'b0;
            end else if (stb_r) begin
                stb_cnt_r <= stb_cnt_r + 5'h01;
            end
        end
    end

    // =========================================================
    // Events: ack fall, character sent, fault fall, paper-out rise.
    // A new event in the cycle of its write-one clear stays set.
    always_comb begin
        ev_set           = '0;
        ev_set[EV_ACK]   = pin_prev_r.ack_n && !pin_in.ack_n;
        ev_set[EV_SENT]  = stb_end;
        ev_set[EV_FAULT] = pin_prev_r.fault_n && !pin_in.fault_n;
        ev_set[EV_PAPER] = !pin_prev_r.paper_out && pin_in.paper_out;
        ev_clr = (acc && pwrite && paddr == OFS_ISTS) ?
                 pwdata[EV_W-1:0] : '0;
        ists_nxt = (ists_r & ~ev_clr) | ev_set;
        int_nxt  = |(ists_nxt & imsk_r);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_prev_r <= 6'h3E;
            ists_r     <= '0;
            int_r      <= 1'b0;
            route_r    <= 3'h7;
        end else if (ce) begin
            pin_prev_r <= pin_in;
            ists_r     <= ists_nxt;
            int_r      <= int_nxt;
            // Stored inverted so the request pins need no gate after the flop.
            route_r    <= int_nxt ? ~route_dec(ctrl_r[CTRL_RT_LO +: 2])
                                  : 3'h7;
        end
    end

    // =========================================================
    // Outputs, all straight from flip-flops.
    assign prdata                 = prdata_r;
    assign pready                 = pready_r;
    assign pslverr                = pslverr_r;
    assign pin_out.printer_data   = porta_r;
    assign pin_out.data_strobe    = stb_r;
    assign pin_out.printer_init_n = init_n_r;
    assign pin_out.cassette_tx    = ctrl_r[CTRL_CTX];
    assign irq_out.nmi_n          = route_r[2];
    assign irq_out.fast_n         = route_r[1];
    assign irq_out.irq_n          = route_r[0];
    assign int_lvl                = int_r;

    // =========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence wr_to(logic [7:0] a);
        acc && pwrite && paddr == a;
    endsequence

    stb_width_a: assert property ($fell(stb_r) |->
        $past(stb_cnt_r) == STB_LAST)
        else $error("Strobe width is not one microsecond.");

    stb_count_a: assert property (stb_r |-> stb_cnt_r <= STB_LAST)
        else $error("Strobe counter ran past its end.");

    stb_gate_a: assert property ($rose(stb_r) |->
        $past(!pin_in.busy && pin_in.selected && pend_r))
        else $error("Strobe started while printer not ready.");

    data_hold_a: assert property (stb_r && $past(stb_r) |->
        $stable(pin_out.printer_data))
        else $error("Printer data changed during strobe.");

    data_map_a: assert property (wr_to(OFS_DATA) ##0 !data_lock |=>
        pin_out.printer_data == $past(pwdata[7:0]))
        else $error("Data pins do not follow port A.");

    init_line_a: assert property (wr_to(OFS_CTRL) |=>
        pin_out.printer_init_n == !$past(pwdata[0]))
        else $error("Init line does not follow control.");

    cass_tx_a: assert property (wr_to(OFS_CTRL) |=>
        pin_out.cassette_tx == $past(pwdata[1]))
        else $error("Cassette transmit does not follow control.");

    irq_route_a: assert property (int_r |->
        $onehot({!irq_out.nmi_n, !irq_out.fast_n, !irq_out.irq_n}))
        else $error("Interrupt not on exactly one input.");

    irq_idle_a: assert property (!int_r |->
        irq_out.nmi_n && irq_out.fast_n && irq_out.irq_n)
        else $error("Interrupt input asserted with no cause.");

endmodule // ppp_top

`default_nettype wire

// >>> verif/ppp_printer_model.sv
// Behavioural printer facing the parallel port pins.
// Assumes all pins are sampled on the rising edge of clk.
`timescale 1ns/1ps
`default_nettype none

// =========================================================
// Printer model
module ppp_printer_model #(
    parameter int BUSY_CYC = 6
) (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire ppp_pkg::ppp_pin_out_s pin_out,
    input  wire logic                  online,
    input  wire logic                  no_paper,
    input  wire logic                  crx,
    output ppp_pkg::ppp_pin_in_s       pin_in,
    output logic [7:0]                 got_r
);
    import ppp_pkg::*;
    logic       stb_r;
    logic       busy_r;
    logic       ack_r;
    logic [3:0] cnt_r;

    // Busy from strobe until the ack; the ack comes after the strobe ends.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst || !pin_out.printer_init_n) begin
            stb_r  <= 1'b0;
            busy_r <= 1'b0;
            ack_r  <= 1'b1;
            cnt_r  <= 4'h0;
            got_r  <= 8'h00;
        end else begin
            stb_r <= pin_out.data_strobe;
            if (pin_out.data_strobe && !stb_r) begin
                got_r  <= pin_out.printer_data;
                busy_r <= 1'b1;
            end
            if (!pin_out.data_strobe && stb_r) begin
                cnt_r <= 4'(BUSY_CYC);
            end else if (cnt_r != 4'h0) begin
                cnt_r <= cnt_r - 4'h1;
            end
            ack_r <= (cnt_r != 4'h2);
            if (cnt_r == 4'h1) begin
                busy_r <= 1'b0;
            end
        end
    end

    // Deselection and paper empty both show as a fault.
    assign pin_in = {ack_r,                 // Acknowledge, low pulse.
                     online & ~no_paper,    // Fault, low.
                     busy_r,                // Busy.
                     no_paper,              // Paper out.
                     online,                // Selected.
                     crx};                  // Cassette receive.
endmodule // ppp_printer_model

`default_nettype wire

// >>> verif/ppp_top_tb.sv
// Self-checking bench for the printer parallel port.
// Assumes the printer model and an APB master run on one 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none

// =========================================================
// Bench
module ppp_top_tb;
    import ppp_pkg::*;
    logic         clk, nrst, psel, penable, pwrite, online, no_paper, crx;
    logic [7:0]   paddr, got_r;
    logic [31:0]  pwdata, prdata, rd;
    logic         pready, pslverr, int_lvl, er;
    ppp_pin_in_s  pin_in;
    ppp_pin_out_s pin_out;
    ppp_irq_s     irq_out;
    int           mismatches, compares, cyc;

    ppp_top u_ppp_top (.clk(clk), .nrst(nrst), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .irq_out(irq_out), .int_lvl(int_lvl));
    ppp_printer_model u_ppp_printer_model (.clk(clk), .nrst(nrst),
        .pin_out(pin_out), .online(online), .no_paper(no_paper), .crx(crx),
        .pin_in(pin_in), .got_r(got_r));

    // =========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // One APB transfer. The request holds until pready is seen high at a
    // rising edge; the answer is taken at that edge and only then released.
    // Only the bench timeout ends a wait that never sees pready.
    task automatic apb(input logic        w,
                       input logic [7:0]  a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        chk(er, e);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
        chk(er, 1'b0);
    endtask

    // Waits for one strobe, measures it and checks what the printer took.
    task automatic watch(input logic [7:0] d);
        int n, k;
        n = 0; k = 0;
        while (pin_out.data_strobe !== 1'b1 && k < 100) begin
            @(negedge clk);
            k++;
        end
        while (pin_out.data_strobe === 1'b1 && n < 100) begin
            chk(pin_out.printer_data, d);
            @(negedge clk);
            n++;
        end
        chk(n, STB_CYC);
        repeat (12) @(negedge clk);
        chk(got_r, d);
    endtask

    // =========================================================
    // Scenarios
    task automatic t_reset;
        chk({21'h0, pin_out}, 32'h2);
        chk({29'h0, irq_out}, 32'h7);
        rdc(OFS_CTRL, 32'(CTRL_RST));
        rdc(OFS_IMSK, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
    endtask

    // Extreme bits high so a shifted bit order shows.
    task automatic t_send;
        wr(OFS_DATA, 32'h81, 1'b0);
        watch(8'h81);
        rdc(OFS_ISTS, 32'h3);
    endtask

    // Every route code lands on exactly one request line.
    task automatic t_irq;
        logic [31:0] ex;
        wr(OFS_IMSK, 32'h2, 1'b0);
        for (int r = 0; r < 4; r++) begin
            wr(OFS_CTRL, 32'(r) << 2, 1'b0);
            repeat (2) @(negedge clk);
            ex = (r == 3) ? 32'h6 : 32'h7 ^ (32'h4 >> r);
            chk({29'h0, irq_out}, ex);
            chk(int_lvl, 1'b1);
        end
        wr(OFS_IMSK, 32'h0, 1'b0);
        repeat (2) @(negedge clk);
        chk({28'h0, int_lvl, irq_out}, 32'h7);
        wr(OFS_ISTS, 32'hF, 1'b0);
        rdc(OFS_ISTS, 32'h0);
    endtask

    // A deselected printer holds the character back; a second one is refused.
    task automatic t_hold;
        int k;
        @(posedge clk);
        online <= 1'b0;
        wr(OFS_DATA, 32'h3C, 1'b0);
        k = 0;
        repeat (40) begin
            @(negedge clk);
            if (pin_out.data_strobe !== 1'b0) k++;
        end
        chk(k, 0);
        rdc(OFS_STAT, 32'h21);
        wr(OFS_DATA, 32'h55, 1'b1);
        @(posedge clk);
        online <= 1'b1;
        watch(8'h3C);
        rdc(OFS_ISTS, 32'h7);
        wr(OFS_ISTS, 32'hF, 1'b0);
    endtask

    task automatic t_ctrl;
        @(posedge clk);
        no_paper <= 1'b1;
        crx <= 1'b1;
        wr(OFS_CTRL, 32'h3, 1'b0);
        repeat (2) @(negedge clk);
        chk(pin_out.printer_init_n, 1'b0);
        chk(pin_out.cassette_tx, 1'b1);
        rdc(OFS_STAT, 32'h1D);
        rdc(OFS_ISTS, 32'hC);
    endtask

    task automatic end_of_test;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // =========================================================
    // Clock, timeout and main sequence
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // The whole run needs about 250 cycles; the ceiling leaves wide margin.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    initial begin
        {nrst, psel, penable, pwrite, no_paper, crx} = 6'h00;
        online = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        mismatches = 0; compares = 0; cyc = 0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        t_reset();
        t_send();
        t_irq();
        t_hold();
        t_ctrl();
        end_of_test();
    end
endmodule // ppp_top_tb

`default_nettype wire
